// [hdl/dro_channel.sv]
// Purpose: One digital or relay output channel with pulse, delay and failsafe.
// Assumes: Single 25 MHz clock, synchronous active-high reset, simple reg port.
// Notes: Register map and field layout live in the package.
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps

module dro_channel #(
    parameter int unsigned TICK_CYCLES = dro_pkg::TICK_CYCLES
) (
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    input wire logic [7:0] ADDR_IN,
    input wire logic [31:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [31:0] RDATA_OUT,
    output logic LINE_O_OUT,
    output logic LINE_OE_OUT,
    output logic CONTACT_OUT,
    output logic ACTIVE_OUT
);

    if (TICK_CYCLES < 2) begin : g_tick_chk
        $error("TICK_CYCLES must be at least 2");
    end

    localparam int TW = $clog2(TICK_CYCLES);

    // ==========================================================
    // Register file
    // ==========================================================
    dro_pkg::dro_cfg_s cfg_q, cfg_d;
    logic [13:0] inact_w_q, inact_w_d;
    logic [13:0] act_w_q, act_w_d;
    logic [13:0] delay_q, delay_d;
    logic [15:0] count_q, count_d;
    logic [13:0] fs_tmo_q, fs_tmo_d;
    logic [31:0] rdata_q, rdata_d;
    logic cmd_act, cmd_deact;
    // Sequencer state is declared here because the status read below returns it.
    dro_pkg::dro_state_e state_q, state_d;
    logic active_q, active_d;

    // Clamp a written width into 1..9999 so a phase never collapses to zero.
    function automatic logic [13:0] clamp_w(input logic [31:0] v);
        if (v[13:0] == 14'h0000 || v[31:14] != '0) begin
            clamp_w = (v[13:0] == 14'h0000 && v[31:14] == '0) ? 14'h0001 : dro_pkg::WIDTH_MAX;
        end else if (v[13:0] > dro_pkg::WIDTH_MAX) begin
            clamp_w = dro_pkg::WIDTH_MAX;
        end else begin
            clamp_w = v[13:0];
        end
    endfunction

    assign cmd_act = WR_IN && ADDR_IN == dro_pkg::ADDR_CMD && WDATA_IN[dro_pkg::CMD_ACT_BIT];
    assign cmd_deact = WR_IN && ADDR_IN == dro_pkg::ADDR_CMD && !cmd_act
        && WDATA_IN[dro_pkg::CMD_DEACT_BIT];

    // Register writes and read mux; unmapped addresses read zero.
    always_comb begin
        cfg_d = cfg_q;
        inact_w_d = inact_w_q;
        act_w_d = act_w_q;
        delay_d = delay_q;
        count_d = count_q;
        fs_tmo_d = fs_tmo_q;
        rdata_d = 32'h0000_0000;
        if (WR_IN) begin
            case (ADDR_IN)
                dro_pkg::ADDR_CTRL: begin
                    cfg_d.dir_out = WDATA_IN[dro_pkg::CTRL_DIR_BIT];
                    cfg_d.drive = dro_pkg::dro_drive_e'(WDATA_IN[dro_pkg::CTRL_TYPE_LSB +: 2]);
                    cfg_d.beh = dro_pkg::dro_beh_e'(WDATA_IN[dro_pkg::CTRL_BEH_LSB +: 2]);
                    cfg_d.style_count = WDATA_IN[dro_pkg::CTRL_STYLE_BIT];
                    cfg_d.fs_act = dro_pkg::dro_fs_e'(WDATA_IN[dro_pkg::CTRL_FS_LSB +: 2]);
                    cfg_d.relay = WDATA_IN[dro_pkg::CTRL_RELAY_BIT];
                end
                dro_pkg::ADDR_INACT_W: inact_w_d = clamp_w(WDATA_IN);
                dro_pkg::ADDR_ACT_W: act_w_d = clamp_w(WDATA_IN);
                dro_pkg::ADDR_DELAY: delay_d = clamp_w(WDATA_IN);
                dro_pkg::ADDR_COUNT: begin
                    count_d = (WDATA_IN[15:0] == 16'h0000) ? 16'h0001 : WDATA_IN[15:0];
                end
                dro_pkg::ADDR_FS_TMO: fs_tmo_d = clamp_w(WDATA_IN);
                default: begin
                end
            endcase
        end
        if (RD_IN) begin
            case (ADDR_IN)
                dro_pkg::ADDR_CTRL: rdata_d = {23'h00_0000, cfg_q};
                dro_pkg::ADDR_INACT_W: rdata_d = {18'h0_0000, inact_w_q};
                dro_pkg::ADDR_ACT_W: rdata_d = {18'h0_0000, act_w_q};
                dro_pkg::ADDR_DELAY: rdata_d = {18'h0_0000, delay_q};
                dro_pkg::ADDR_COUNT: rdata_d = {16'h0000, count_q};
                dro_pkg::ADDR_FS_TMO: rdata_d = {18'h0_0000, fs_tmo_q};
                dro_pkg::ADDR_STATUS: rdata_d = {26'h000_0000, state_q, active_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Registered configuration; defaults give input direction, sink, manual, continuous.
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            cfg_q <= '0;
            inact_w_q <= dro_pkg::WIDTH_RST;
            act_w_q <= dro_pkg::WIDTH_RST;
            delay_q <= dro_pkg::WIDTH_RST;
            count_q <= dro_pkg::COUNT_RST;
            fs_tmo_q <= dro_pkg::FS_TMO_RST;
            rdata_q <= 32'h0000_0000;
        end else begin
            cfg_q <= cfg_d;
            inact_w_q <= inact_w_d;
            act_w_q <= act_w_d;
            delay_q <= delay_d;
            count_q <= count_d;
            fs_tmo_q <= fs_tmo_d;
            rdata_q <= rdata_d;
        end
    end

    assign RDATA_OUT = rdata_q;

    // ==========================================================
    // 100 ms tick and failsafe timer
    // ==========================================================
    logic [TW-1:0] pre_q, pre_d;
    logic tick;
    logic [3:0] sub_q, sub_d;
    logic [13:0] fs_cnt_q, fs_cnt_d;
    logic fs_fire;

    assign tick = (pre_q == TW'(TICK_CYCLES - 1));

    // Seconds built from ten ticks; any command restarts the failsafe count.
    always_comb begin
        pre_d = tick ? '0 : pre_q + 1'b1;
        sub_d = sub_q;
        fs_cnt_d = fs_cnt_q;
        fs_fire = 1'b0;
        if (cmd_act || cmd_deact) begin
            sub_d = 4'h0;
            fs_cnt_d = 14'h0000;
        end else if (tick) begin
            if (sub_q == 4'(dro_pkg::TICKS_PER_SEC - 1)) begin
                sub_d = 4'h0;
                if (fs_cnt_q + 14'h0001 >= fs_tmo_q) begin
                    fs_fire = 1'b1;
                    fs_cnt_d = 14'h0000;
                end else begin
                    fs_cnt_d = fs_cnt_q + 14'h0001;
                end
            end else begin
                sub_d = sub_q + 4'h1;
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            pre_q <= '0;
            sub_q <= 4'h0;
            fs_cnt_q <= 14'h0000;
        end else begin
            pre_q <= pre_d;
            sub_q <= sub_d;
            fs_cnt_q <= fs_cnt_d;
        end
    end

    // ==========================================================
    // Output sequencer
    // ==========================================================
    logic [13:0] ph_q, ph_d;
    logic [15:0] per_q, per_d;

    // Phase counters load a width and count ticks; a phase ends when they hit one.
    always_comb begin
        state_d = state_q;
        active_d = active_q;
        ph_d = ph_q;
        per_d = per_q;
        case (state_q)
            dro_pkg::ST_IDLE: begin
                if (cmd_act) begin
                    case (cfg_q.beh)
                        dro_pkg::BEH_PULSE: begin
                            state_d = dro_pkg::ST_ACT_PH;
                            active_d = 1'b1;
                            ph_d = act_w_q;
                            per_d = count_q;
                        end
                        dro_pkg::BEH_DLY_ON: begin
                            state_d = dro_pkg::ST_DLY_ON;
                            active_d = 1'b0;
                            ph_d = delay_q;
                        end
                        dro_pkg::BEH_DLY_OFF: begin
                            state_d = dro_pkg::ST_DLY_OFF;
                            active_d = 1'b1;
                            ph_d = delay_q;
                        end
                        default: active_d = 1'b1;
                    endcase
                end else if (cmd_deact) begin
                    state_d = dro_pkg::ST_DLY_OFF;
                    ph_d = delay_q;
                end
            end
            dro_pkg::ST_ACT_PH: begin
                if (tick) begin
                    if (ph_q <= 14'h0001) begin
                        state_d = dro_pkg::ST_INACT_PH;
                        active_d = 1'b0;
                        ph_d = inact_w_q;
                    end else begin
                        ph_d = ph_q - 14'h0001;
                    end
                end
            end
            dro_pkg::ST_INACT_PH: begin
                if (tick) begin
                    if (ph_q > 14'h0001) begin
                        ph_d = ph_q - 14'h0001;
                    end else if (cfg_q.style_count && per_q <= 16'h0001) begin
                        state_d = dro_pkg::ST_IDLE;
                    end else begin
                        state_d = dro_pkg::ST_ACT_PH;
                        active_d = 1'b1;
                        ph_d = act_w_q;
                        per_d = cfg_q.style_count ? per_q - 16'h0001 : per_q;
                    end
                end
            end
            dro_pkg::ST_DLY_ON: begin
                if (tick) begin
                    if (ph_q <= 14'h0001) begin
                        state_d = dro_pkg::ST_IDLE;
                        active_d = 1'b1;
                    end else begin
                        ph_d = ph_q - 14'h0001;
                    end
                end
            end
            dro_pkg::ST_DLY_OFF: begin
                if (tick) begin
                    if (ph_q <= 14'h0001) begin
                        state_d = dro_pkg::ST_IDLE;
                        active_d = 1'b0;
                    end else begin
                        ph_d = ph_q - 14'h0001;
                    end
                end
            end
            default: begin
                state_d = dro_pkg::ST_IDLE;
                active_d = 1'b0;
            end
        endcase
        // A deactivate during a running sequence stops it after the delay.
        if (state_q != dro_pkg::ST_IDLE && cmd_deact) begin
            state_d = dro_pkg::ST_DLY_OFF;
            ph_d = delay_q;
        end
        // Failsafe overrides any sequence and leaves a steady level.
        if (fs_fire && cfg_q.fs_act != dro_pkg::FS_NONE) begin
            state_d = dro_pkg::ST_IDLE;
            active_d = (cfg_q.fs_act == dro_pkg::FS_ACTIVATE);
        end
        // Leaving pulse behaviour ends a continuous train.
        if (cfg_q.beh != dro_pkg::BEH_PULSE &&
            (state_q == dro_pkg::ST_ACT_PH || state_q == dro_pkg::ST_INACT_PH)) begin
            state_d = dro_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            state_q <= dro_pkg::ST_IDLE;
            active_q <= 1'b0;
            ph_q <= 14'h0000;
            per_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            active_q <= active_d;
            ph_q <= ph_d;
            per_q <= per_d;
        end
    end

    // ==========================================================
    // Pin drive
    // ==========================================================
    dro_pkg::dro_pin_s pin;

    // Drive polarity per type; the enable stays low unless direction is output.
    always_comb begin
        pin.contact = cfg_q.relay && active_q;
        case (cfg_q.drive)
            dro_pkg::DRIVE_SOURCE: begin
                pin.line_o = 1'b1;
                pin.line_oe = active_q;
            end
            dro_pkg::DRIVE_BOTH: begin
                pin.line_o = active_q;
                pin.line_oe = 1'b1;
            end
            default: begin
                pin.line_o = 1'b0;
                pin.line_oe = active_q;
            end
        endcase
        if (!cfg_q.dir_out || cfg_q.relay) begin
            pin.line_oe = 1'b0;
        end
    end

    assign LINE_O_OUT = pin.line_o;
    assign LINE_OE_OUT = pin.line_oe;
    assign CONTACT_OUT = pin.contact;
    assign ACTIVE_OUT = active_q;

endmodule

// [hdl/dro_pkg.sv]
// Purpose: Shared constants and types for the digital/relay output channel.
// Assumes: 25 MHz system clock, 32-bit register port.
// Notes: All register offsets are byte addresses on aligned words.
package dro_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned TICK_MS = 100;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned TICKS_PER_SEC = 1000 / TICK_MS;

    // ==========================================================
    // Register offsets
    // ==========================================================
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_INACT_W = 8'h08;
    localparam logic [7:0] ADDR_ACT_W = 8'h0C;
    localparam logic [7:0] ADDR_DELAY = 8'h10;
    localparam logic [7:0] ADDR_COUNT = 8'h14;
    localparam logic [7:0] ADDR_FS_TMO = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1C;

    // ==========================================================
    // Control field positions
    // ==========================================================
    localparam int unsigned CTRL_DIR_BIT = 0;
    localparam int unsigned CTRL_TYPE_LSB = 1;
    localparam int unsigned CTRL_BEH_LSB = 3;
    localparam int unsigned CTRL_STYLE_BIT = 5;
    localparam int unsigned CTRL_FS_LSB = 6;
    localparam int unsigned CTRL_RELAY_BIT = 8;
    localparam int unsigned CMD_ACT_BIT = 0;
    localparam int unsigned CMD_DEACT_BIT = 1;

    // ==========================================================
    // Reset values and width limit
    // ==========================================================
    localparam logic [13:0] WIDTH_RST = 14'h0001;
    localparam logic [15:0] COUNT_RST = 16'h0001;
    localparam logic [13:0] FS_TMO_RST = 14'h001E;
    localparam logic [13:0] WIDTH_MAX = 14'h270F;

    typedef enum logic [1:0] {
        DRIVE_SINK = 2'h0,
        DRIVE_SOURCE = 2'h1,
        DRIVE_BOTH = 2'h2
    } dro_drive_e;

    typedef enum logic [1:0] {
        BEH_MANUAL = 2'h0,
        BEH_PULSE = 2'h1,
        BEH_DLY_ON = 2'h2,
        BEH_DLY_OFF = 2'h3
    } dro_beh_e;

    typedef enum logic [1:0] {
        FS_NONE = 2'h0,
        FS_ACTIVATE = 2'h1,
        FS_DEACTIVATE = 2'h2
    } dro_fs_e;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ACT_PH = 5'b00010,
        ST_INACT_PH = 5'b00100,
        ST_DLY_ON = 5'b01000,
        ST_DLY_OFF = 5'b10000
    } dro_state_e;

    // Configuration bundle held by software.
    typedef struct packed {
        logic dir_out;
        dro_drive_e drive;
        dro_beh_e beh;
        logic style_count;
        dro_fs_e fs_act;
        logic relay;
    } dro_cfg_s;

    // Drive for one two-signal line plus relay contact.
    typedef struct packed {
        logic line_o;
        logic line_oe;
        logic contact;
    } dro_pin_s;

endpackage

// [tb/dro_load.sv]
// Purpose: Model of the load wired to the channel line and relay contact.
// Assumes: The line carries a pull-up inside the load.
// Notes: A released line reads as supply level, never as a stale value.
`timescale 1ns/1ps
module dro_load (
    input wire logic line_o_in,
    input wire logic line_oe_in,
    input wire logic contact_in,
    output logic line_lvl_out,
    output logic lamp_on_out
);
    // =========================================================
    // Line and contact
    // =========================================================
    // The pull-up wins whenever the channel lets go of the line.
    assign line_lvl_out = line_oe_in ? line_o_in : 1'b1;
    // A closed contact powers the lamp on the high-voltage side.
    assign lamp_on_out = contact_in;
endmodule

// [tb/dro_channel_checker.sv]
// Purpose: Port-level assertions for the output channel.
// Assumes: Control word mirrored from writes seen at the register port.
// Notes: Bound to every channel instance.
`timescale 1ns/1ps
module dro_channel_checker (
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    input wire logic [7:0] ADDR_IN,
    input wire logic [31:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic [31:0] RDATA_OUT,
    input wire logic LINE_O_OUT,
    input wire logic LINE_OE_OUT,
    input wire logic CONTACT_OUT,
    input wire logic ACTIVE_OUT
);
    logic [8:0] ctrl_q;
    logic [8:0] ctrl_d;
    logic pin_en;
    // =========================================================
    // Control mirror
    // =========================================================
    // Updates on the same edge as the design copy, so both agree each cycle.
    always_comb begin
        ctrl_d = ctrl_q;
        if (WR_IN && ADDR_IN == dro_pkg::ADDR_CTRL) begin
            ctrl_d = WDATA_IN[8:0];
        end
    end
    always_ff @(posedge CLK_IN) begin
        ctrl_q <= RESET_IN ? 9'h000 : ctrl_d;
    end
    // A relay channel never drives the line.
    assign pin_en = ctrl_q[0] && !ctrl_q[8];
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);
    // =========================================================
    // Properties
    // =========================================================
    sequence s_act_cmd;
        WR_IN && ADDR_IN == dro_pkg::ADDR_CMD && WDATA_IN[0];
    endsequence
    sequence s_deact_cmd;
        WR_IN && ADDR_IN == dro_pkg::ADDR_CMD && WDATA_IN[1] && !WDATA_IN[0];
    endsequence
    property p_rst;
        $fell(RESET_IN) |-> !ACTIVE_OUT && !LINE_OE_OUT && !CONTACT_OUT;
    endproperty
    property p_dir;
        !pin_en |-> !LINE_OE_OUT;
    endproperty
    property p_sink;
        pin_en && ctrl_q[2:1] == 2'h0 |-> LINE_OE_OUT == ACTIVE_OUT && !LINE_O_OUT;
    endproperty
    property p_src;
        pin_en && ctrl_q[2:1] == 2'h1 |-> LINE_OE_OUT == ACTIVE_OUT && LINE_O_OUT;
    endproperty
    property p_both;
        pin_en && ctrl_q[2:1] == 2'h2 |-> LINE_OE_OUT && LINE_O_OUT == ACTIVE_OUT;
    endproperty
    property p_relay;
        CONTACT_OUT == (ctrl_q[8] && ACTIVE_OUT);
    endproperty
    property p_manual;
        s_act_cmd ##0 (ctrl_q[4:3] == 2'h0 && !ACTIVE_OUT) |=> ACTIVE_OUT;
    endproperty
    property p_deact_wait;
        s_deact_cmd ##0 (ctrl_q[4:3] == 2'h0 && ACTIVE_OUT) |=> ACTIVE_OUT;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle after reset");
    a_dir: assert property (p_dir) else $error("line driven while not output");
    a_sink: assert property (p_sink) else $error("sink drive wrong");
    a_src: assert property (p_src) else $error("source drive wrong");
    a_both: assert property (p_both) else $error("sink and source drive wrong");
    a_relay: assert property (p_relay) else $error("contact disagrees with state");
    a_manual: assert property (p_manual) else $error("manual activate missed");
    a_deact_wait: assert property (p_deact_wait) else $error("deactivate not delayed");
endmodule

bind dro_channel dro_channel_checker chk_u (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN),
    .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
    .RDATA_OUT(RDATA_OUT), .LINE_O_OUT(LINE_O_OUT), .LINE_OE_OUT(LINE_OE_OUT),
    .CONTACT_OUT(CONTACT_OUT), .ACTIVE_OUT(ACTIVE_OUT));

// [tb/dro_channel_tb_top.sv]
// Purpose: Self-checking bench for the output channel.
// Assumes: A short tick of ten clocks so delays stay brief.
// Notes: Tick phase is free running, so durations are checked as ranges.
`timescale 1ns/1ps
module dro_channel_tb_top;
    localparam int TCK = 10;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [31:0] rdata;
    logic line_o, line_oe, contact, active, lvl, lamp;
    logic [31:0] rv;
    int n, hi, rs;
    int err_count = 0;
    int compares = 0;
    logic [7:0] rmap [8] = '{dro_pkg::ADDR_CTRL, dro_pkg::ADDR_INACT_W, dro_pkg::ADDR_ACT_W,
        dro_pkg::ADDR_DELAY, dro_pkg::ADDR_COUNT, dro_pkg::ADDR_FS_TMO, dro_pkg::ADDR_STATUS,
        8'h20};
    logic [31:0] rexp [8] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0001, 32'h0000_0001,
        32'h0000_0001, 32'h0000_001E, 32'h0000_0002, 32'h0000_0000};
    // =========================================================
    // Clock, design and load
    // =========================================================
    always #20 clk = ~clk;
    dro_channel #(.TICK_CYCLES(TCK)) dut_u (.CLK_IN(clk), .RESET_IN(rst), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr_s), .RD_IN(rd_s), .RDATA_OUT(rdata),
        .LINE_O_OUT(line_o), .LINE_OE_OUT(line_oe), .CONTACT_OUT(contact),
        .ACTIVE_OUT(active));
    dro_load load_u (.line_o_in(line_o), .line_oe_in(line_oe), .contact_in(contact),
        .line_lvl_out(lvl), .lamp_on_out(lamp));
    // =========================================================
    // Tasks
    // =========================================================
    task automatic conclude();
        $display("mismatches %0d of %0d compares", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Pins packed as line enable, lamp, state and level seen by the load.
    task automatic chk_pins(input logic [3:0] exp);
        chk({28'h000_0000, line_oe, lamp, active, lvl}, {28'h000_0000, exp});
    endtask
    task automatic chk_rng(input int v, input int lo, input int hi_lim);
        chk({31'h0000_0000, (v >= lo && v <= hi_lim)}, 32'h0000_0001);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        d = rdata;
    endtask
    // Bounded wait for the output state; running out ends the run.
    task automatic wait_act(input logic v, input int lim, output int cnt);
        cnt = 0;
        while (active !== v) begin
            @(posedge clk);
            #1;
            cnt++;
            if (cnt > lim) begin
                err_count++;
                $display("[ERR] t=%0t got=%h exp=%h", $time, active, v);
                conclude();
            end
        end
    endtask
    task automatic watch(input int cyc, output int h, output int r);
        logic prev;
        h = 0;
        r = 0;
        prev = active;
        repeat (cyc) begin
            @(posedge clk);
            #1;
            h += (active === 1'b1);
            r += (active === 1'b1 && prev !== 1'b1);
            prev = active;
        end
    endtask
    // =========================================================
    // Sequence of tests
    // =========================================================
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        foreach (rmap[i]) begin
            rd(rmap[i], rv);
            chk(rv, rexp[i]);
        end
        wr(dro_pkg::ADDR_ACT_W, 32'h0000_0000);
        rd(dro_pkg::ADDR_ACT_W, rv);
        chk(rv, 32'h0000_0001);
        wr(dro_pkg::ADDR_INACT_W, 32'h0000_FFFF);
        rd(dro_pkg::ADDR_INACT_W, rv);
        chk(rv, 32'h0000_270F);
        // Manual control through sink and source, direction off, then both with a delayed deactivate.
        wr(dro_pkg::ADDR_CTRL, 32'h0000_0001);
        chk_pins(4'h1);
        wr(dro_pkg::ADDR_CMD, 32'h0000_0001);
        chk_pins(4'hA);
        wr(dro_pkg::ADDR_CTRL, 32'h0000_0003);
        chk_pins(4'hB);
        wr(dro_pkg::ADDR_CTRL, 32'h0000_0004);
        chk_pins(4'h3);
        wr(dro_pkg::ADDR_CTRL, 32'h0000_0005);
        wr(dro_pkg::ADDR_DELAY, 32'h0000_0003);
        wr(dro_pkg::ADDR_CMD, 32'h0000_0002);
        wait_act(1'b0, 40, n);
        chk_rng(n, 2 * TCK, 3 * TCK + 2);
        chk_pins(4'h8);
        // Relay contact follows the state and leaves the line alone.
        wr(dro_pkg::ADDR_CTRL, 32'h0000_0101);
        wr(dro_pkg::ADDR_DELAY, 32'h0000_0001);
        wr(dro_pkg::ADDR_CMD, 32'h0000_0001);
        chk_pins(4'h7);
        wr(dro_pkg::ADDR_CMD, 32'h0000_0002);
        wait_act(1'b0, 15, n);
        chk_pins(4'h1);
        // Counted pulses: two periods of two ticks on, three ticks off.
        wr(dro_pkg::ADDR_ACT_W, 32'h0000_0002);
        wr(dro_pkg::ADDR_INACT_W, 32'h0000_0003);
        wr(dro_pkg::ADDR_COUNT, 32'h0000_0002);
        wr(dro_pkg::ADDR_CTRL, 32'h0000_0029);
        wr(dro_pkg::ADDR_CMD, 32'h0000_0001);
        watch(150, hi, rs);
        chk_rng(hi, 3 * TCK, 4 * TCK + 2);
        chk(rs, 1);
        chk_pins(4'h1);
        // Continuous pulses run on until a reset lands mid-train.
        wr(dro_pkg::ADDR_CTRL, 32'h0000_0009);
        wr(dro_pkg::ADDR_CMD, 32'h0000_0001);
        watch(250, hi, rs);
        chk_rng(rs, 4, 5);
        chk_rng(hi, 9 * TCK, 11 * TCK);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk_pins(4'h1);
        watch(60, hi, rs);
        chk(hi, 0);
        // Delay on, then delay off, each two ticks.
        wr(dro_pkg::ADDR_DELAY, 32'h0000_0002);
        wr(dro_pkg::ADDR_CTRL, 32'h0000_0011);
        wr(dro_pkg::ADDR_CMD, 32'h0000_0001);
        wait_act(1'b1, 40, n);
        chk_rng(n, TCK + 1, 2 * TCK + 2);
        wr(dro_pkg::ADDR_CTRL, 32'h0000_0019);
        wr(dro_pkg::ADDR_CMD, 32'h0000_0001);
        wait_act(1'b0, 40, n);
        chk_rng(n, TCK + 1, 2 * TCK);
        // Failsafe of one second; a command part way through restarts it.
        wr(dro_pkg::ADDR_FS_TMO, 32'h0000_0001);
        wr(dro_pkg::ADDR_CTRL, 32'h0000_0041);
        repeat (60) @(posedge clk);
        wr(dro_pkg::ADDR_CMD, 32'h0000_0002);
        wait_act(1'b1, 130, n);
        chk_rng(n, 85, 10 * TCK + 12);
        wr(dro_pkg::ADDR_CTRL, 32'h0000_0081);
        wait_act(1'b0, 140, n);
        chk_rng(n, 10 * TCK - 12, 10 * TCK);
        wr(dro_pkg::ADDR_CTRL, 32'h0000_0001);
        watch(130, hi, rs);
        chk(hi, 0);
        conclude();
    end
    // Watchdog for a hung run.
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0000_0000, 32'h0000_0001);
        conclude();
    end
endmodule
